/* srw_pkg.sv */
// Purpose: Shared constants and types for the serializer rate and warm-up block
// Assumes: Special-function registers on an 8-bit address, 8-bit data port
// Notes: All counts are in serializer clock ticks
package srw_pkg;

	// ************************************************************
	// Register addresses
	// ************************************************************
	localparam logic [7:0] ADDR_SYMBOL_GROUP_IN = 8'hAB;
	localparam logic [7:0] ADDR_SYMBOL_RATE_LOW = 8'hAC;
	localparam logic [7:0] ADDR_SYMBOL_RATE_HIGH = 8'hAD;
	localparam logic [7:0] ADDR_WARMUP_DIV_AMP = 8'hAE;
	localparam logic [7:0] ADDR_WARMUP_OSC = 8'hAF;

	// ************************************************************
	// Widths, fields and reset values
	// ************************************************************
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int RATE_HIGH_W = 7;
	localparam int WARM_W = 4;
	localparam int WARM_CNT_W = 10;
	localparam int DIV_WARM_HI = 7;
	localparam int DIV_WARM_LO = 4;
	localparam int AMP_WARM_HI = 3;
	localparam int AMP_WARM_LO = 0;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam logic [WARM_CNT_W-1:0] DIV_WARM_SCALE = 10'h004;
	localparam logic [WARM_CNT_W-1:0] OSC_WARM_SCALE = 10'h040;

	// ************************************************************
	// Data-out behaviour when no byte is available
	// ************************************************************
	localparam logic [1:0] RUNOUT_POWER_DOWN = 2'h0;
	localparam logic [1:0] RUNOUT_REPEAT = 2'h1;
	localparam logic [1:0] RUNOUT_ZEROS = 2'h2;
	localparam logic [1:0] RUNOUT_ONES = 2'h3;

	typedef enum logic [2:0] {
		SRW_IDLE,
		SRW_WARM_OSC,
		SRW_WARM_DIV,
		SRW_WARM_AMP,
		SRW_SEND
	} srw_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} srw_sfr_req_t;

endpackage

/* srw_serializer.sv */
// Purpose: Holding register, symbol pacing and warm-up sequencing of the output serializer
// Assumes: All inputs synchronous to clk; control fields come from the neighbouring block
// Notes: One clock domain; warm-up and rate counts advance on the serializer tick
`timescale 1ns/1ns

// ************************************************************
// Byte FIFO between holding register and shift stage
// ************************************************************
module srw_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic push;
	logic pull;

	assign in_ready = count != (PW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pull = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pull) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pull) begin
				count <= count + 1'b1;
			end else if (pull && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// ************************************************************
// Serializer top
// ************************************************************
module srw_serializer (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire srw_pkg::srw_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic ods_enable,
	input wire logic fsk_mode,
	input wire logic [2:0] serializer_clock_divider,
	input wire logic [2:0] group_width,
	input wire logic [1:0] shift_ctrl,
	output logic data_empty,
	output logic sym_out,
	output logic sym_strobe,
	output logic pa_on,
	output logic div_on,
	output logic lc_oscillator_on
);
	localparam int WARM_CNT_W = srw_pkg::WARM_CNT_W;
	logic [7:0] tx_symbol_group_in;
	logic [7:0] symbol_rate_low;
	logic [srw_pkg::RATE_HIGH_W-1:0] symbol_rate_high;
	logic [7:0] warmup_divider_amplifier;
	logic [srw_pkg::WARM_W-1:0] oscillator_warmup_count;
	logic [srw_pkg::WARM_W-1:0] amplifier_warmup_count;
	logic [srw_pkg::WARM_W-1:0] divider_warmup_count;
	logic wr_group;
	logic notify;
	logic pending;
	logic transfer;
	logic fifo_in_ready;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic pop;
	logic [2:0] ck_cnt;
	logic tick;
	logic [14:0] rate_div;
	logic [14:0] rate_lim;
	logic [14:0] rate_cnt;
	logic advance;
	logic [srw_pkg::WARM_CNT_W-1:0] warm_cnt;
	logic [srw_pkg::WARM_CNT_W-1:0] warm_target;
	logic warm_done;
	srw_pkg::srw_state_t state;
	srw_pkg::srw_state_t next_state;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [7:0] last_group;
	logic [7:0] next_last;
	logic [2:0] bit_idx;
	logic [2:0] next_idx;
	logic next_sym;
	logic next_strobe;
	logic [7:0] group_src;
	logic src_ok;

	assign amplifier_warmup_count =
		warmup_divider_amplifier[srw_pkg::AMP_WARM_HI:srw_pkg::AMP_WARM_LO];
	assign divider_warmup_count =
		warmup_divider_amplifier[srw_pkg::DIV_WARM_HI:srw_pkg::DIV_WARM_LO];

	// ************************************************************
	// Register port
	// ************************************************************
	assign wr_group = ce && sfr_req.wr && sfr_req.addr == srw_pkg::ADDR_SYMBOL_GROUP_IN;

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_symbol_group_in <= srw_pkg::REG_RESET;
			symbol_rate_low <= srw_pkg::REG_RESET;
			symbol_rate_high <= srw_pkg::REG_RESET[srw_pkg::RATE_HIGH_W-1:0];
			warmup_divider_amplifier <= srw_pkg::REG_RESET;
			oscillator_warmup_count <= srw_pkg::REG_RESET[srw_pkg::WARM_W-1:0];
		end else if (ce && sfr_req.wr) begin
			unique case (sfr_req.addr)
				srw_pkg::ADDR_SYMBOL_GROUP_IN: tx_symbol_group_in <= sfr_req.wdata;
				srw_pkg::ADDR_SYMBOL_RATE_LOW: symbol_rate_low <= sfr_req.wdata;
				srw_pkg::ADDR_SYMBOL_RATE_HIGH: begin
					symbol_rate_high <= sfr_req.wdata[srw_pkg::RATE_HIGH_W-1:0];
				end
				srw_pkg::ADDR_WARMUP_DIV_AMP: warmup_divider_amplifier <= sfr_req.wdata;
				srw_pkg::ADDR_WARMUP_OSC: begin
					oscillator_warmup_count <= sfr_req.wdata[srw_pkg::WARM_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Upper bits of the two partial registers are never stored, so they read zero
	always_ff @(posedge clk) begin
		if (rst) begin
			sfr_rdata <= srw_pkg::READ_UNMAPPED;
		end else if (ce && sfr_req.rd) begin
			unique case (sfr_req.addr)
				srw_pkg::ADDR_SYMBOL_GROUP_IN: sfr_rdata <= tx_symbol_group_in;
				srw_pkg::ADDR_SYMBOL_RATE_LOW: sfr_rdata <= symbol_rate_low;
				srw_pkg::ADDR_SYMBOL_RATE_HIGH: sfr_rdata <= {1'b0, symbol_rate_high};
				srw_pkg::ADDR_WARMUP_DIV_AMP: sfr_rdata <= warmup_divider_amplifier;
				srw_pkg::ADDR_WARMUP_OSC: sfr_rdata <= {4'h0, oscillator_warmup_count};
				default: sfr_rdata <= srw_pkg::READ_UNMAPPED;
			endcase
		end
	end

	// ************************************************************
	// Holding register handshake
	// ************************************************************
	// Pulse is one cycle late so the byte is already stable in the holding register
	always_ff @(posedge clk) begin
		if (rst) begin
			notify <= 1'b0;
		end else if (ce) begin
			notify <= wr_group;
		end
	end

	// A byte rewritten while pending is not moved until its notify has passed
	assign transfer = pending && !notify && fifo_in_ready && ce;

	always_ff @(posedge clk) begin
		if (rst) begin
			pending <= 1'b0;
		end else if (ce) begin
			if (notify) begin
				pending <= 1'b1;
			end else if (transfer) begin
				pending <= 1'b0;
			end
		end
	end

	// A fresh write outranks a transfer of the previous byte
	always_ff @(posedge clk) begin
		if (rst) begin
			data_empty <= 1'b1;
		end else if (ce) begin
			if (wr_group) begin
				data_empty <= 1'b0;
			end else if (transfer) begin
				data_empty <= 1'b1;
			end
		end
	end

	srw_fifo #(
		.WIDTH(srw_pkg::DATA_W),
		.DEPTH(srw_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(pending && !notify && ce),
		.in_ready(fifo_in_ready),
		.in_data(tx_symbol_group_in),
		.out_valid(fifo_valid),
		.out_ready(pop && ce),
		.out_data(fifo_data)
	);

	// ************************************************************
	// Serializer tick and symbol rate
	// ************************************************************
	assign tick = ck_cnt == serializer_clock_divider;

	always_ff @(posedge clk) begin
		if (rst) begin
			ck_cnt <= '0;
		end else if (ce) begin
			ck_cnt <= tick ? '0 : ck_cnt + 1'b1;
		end
	end

	// A zero divisor would stall the link, so it behaves as one
	assign rate_div = {symbol_rate_high, symbol_rate_low};
	assign rate_lim = rate_div == '0 ? 15'h0001 : rate_div;
	assign advance = state == srw_pkg::SRW_SEND && tick
		&& ({1'b0, rate_cnt} + 16'h0001) >= {1'b0, rate_lim};

	always_ff @(posedge clk) begin
		if (rst) begin
			rate_cnt <= '0;
		end else if (ce) begin
			if (state != srw_pkg::SRW_SEND || advance) begin
				rate_cnt <= '0;
			end else if (tick) begin
				rate_cnt <= rate_cnt + 1'b1;
			end
		end
	end

	// ************************************************************
	// Warm-up timing
	// ************************************************************
	always_comb begin
		unique case (state)
			srw_pkg::SRW_WARM_OSC: begin
				warm_target = WARM_CNT_W'(oscillator_warmup_count) * srw_pkg::OSC_WARM_SCALE;
			end
			srw_pkg::SRW_WARM_DIV: begin
				warm_target = WARM_CNT_W'(divider_warmup_count) * srw_pkg::DIV_WARM_SCALE;
			end
			srw_pkg::SRW_WARM_AMP: warm_target = WARM_CNT_W'(amplifier_warmup_count);
			default: warm_target = '0;
		endcase
	end

	assign warm_done = ({1'b0, warm_cnt} + 11'h001) >= {1'b0, warm_target};

	always_ff @(posedge clk) begin
		if (rst) begin
			warm_cnt <= '0;
		end else if (ce) begin
			if (next_state != state) begin
				warm_cnt <= '0;
			end else if (tick) begin
				warm_cnt <= warm_cnt + 1'b1;
			end
		end
	end

	// ************************************************************
	// Sequencer and shift stage
	// ************************************************************
	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_last = last_group;
		next_idx = bit_idx;
		next_sym = sym_out;
		next_strobe = 1'b0;
		pop = 1'b0;
		src_ok = 1'b1;
		group_src = last_group;
		if (fifo_valid) begin
			group_src = fifo_data;
		end else begin
			unique case (shift_ctrl)
				srw_pkg::RUNOUT_POWER_DOWN: src_ok = 1'b0;
				srw_pkg::RUNOUT_REPEAT: group_src = last_group;
				srw_pkg::RUNOUT_ZEROS: group_src = 8'h00;
				srw_pkg::RUNOUT_ONES: group_src = 8'hFF;
			endcase
		end
		unique case (state)
			srw_pkg::SRW_IDLE: begin
				if (ods_enable && fifo_valid) begin
					pop = 1'b1;
					next_shreg = fifo_data;
					next_last = fifo_data;
					next_idx = '0;
					next_state = srw_pkg::SRW_WARM_OSC;
				end
			end
			srw_pkg::SRW_WARM_OSC: begin
				if (tick && warm_done) begin
					next_state = srw_pkg::SRW_WARM_DIV;
				end
			end
			srw_pkg::SRW_WARM_DIV: begin
				if (tick && warm_done) begin
					next_state = srw_pkg::SRW_WARM_AMP;
				end
			end
			srw_pkg::SRW_WARM_AMP: begin
				if (tick && warm_done) begin
					next_state = srw_pkg::SRW_SEND;
					next_sym = shreg[0];
					next_strobe = 1'b1;
				end
			end
			srw_pkg::SRW_SEND: begin
				if (advance) begin
					if (bit_idx != group_width) begin
						next_shreg = shreg >> 1;
						next_idx = bit_idx + 1'b1;
					end else if (src_ok) begin
						pop = fifo_valid;
						next_shreg = group_src;
						next_last = group_src;
						next_idx = '0;
					end else begin
						next_state = srw_pkg::SRW_IDLE;
						next_sym = 1'b0;
					end
					if (next_state == srw_pkg::SRW_SEND) begin
						// OOK re-warms on a rising symbol; the symbol waits out the warm-up
						if (!fsk_mode && !sym_out && next_shreg[0]) begin
							next_state = srw_pkg::SRW_WARM_OSC;
						end else begin
							next_sym = next_shreg[0];
							next_strobe = 1'b1;
						end
					end
				end
			end
		endcase
		if (!ods_enable) begin
			next_state = srw_pkg::SRW_IDLE;
			next_sym = 1'b0;
			next_strobe = 1'b0;
			pop = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= srw_pkg::SRW_IDLE;
		end else if (ce) begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			shreg <= '0;
			last_group <= '0;
			bit_idx <= '0;
			sym_out <= 1'b0;
			sym_strobe <= 1'b0;
		end else if (ce) begin
			shreg <= next_shreg;
			last_group <= next_last;
			bit_idx <= next_idx;
			sym_out <= next_sym;
			sym_strobe <= next_strobe;
		end
	end

	assign lc_oscillator_on = state != srw_pkg::SRW_IDLE;
	assign div_on = state == srw_pkg::SRW_WARM_DIV || state == srw_pkg::SRW_WARM_AMP
		|| state == srw_pkg::SRW_SEND;
	assign pa_on = state == srw_pkg::SRW_WARM_AMP || state == srw_pkg::SRW_SEND;

	// ************************************************************
	// Checks
	// ************************************************************
	chk_empty_clear: assert property (@(posedge clk) disable iff (rst)
		wr_group |=> !data_empty) else $error("empty flag not cleared by write");
	chk_notify_pulse: assert property (@(posedge clk) disable iff (rst)
		wr_group |=> notify && tx_symbol_group_in == $past(sfr_req.wdata))
		else $error("notify pulse missing or data unstable");
	chk_lsb_order: assert property (@(posedge clk) disable iff (rst)
		(ce && advance && bit_idx != group_width && next_state == srw_pkg::SRW_SEND && sym_out)
		|=> sym_out == $past(shreg[1])) else $error("symbol order wrong");
	chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		(ce && sfr_req.rd && sfr_req.addr == srw_pkg::ADDR_WARMUP_OSC)
		|=> sfr_rdata[7:4] == 4'h0) else $error("reserved bits read nonzero");
	chk_div_warm: assert property (@(posedge clk) disable iff (rst)
		state == srw_pkg::SRW_WARM_DIV |-> warm_target == {divider_warmup_count, 2'b00} + 10'h000)
		else $error("divider warm length wrong");
	chk_amp_warm: assert property (@(posedge clk) disable iff (rst)
		(state == srw_pkg::SRW_WARM_AMP && ce && tick && warm_cnt >= 10'(amplifier_warmup_count))
		|=> state != srw_pkg::SRW_WARM_AMP) else $error("amplifier warm overrun");
	chk_osc_warm: assert property (@(posedge clk) disable iff (rst)
		state == srw_pkg::SRW_WARM_OSC |-> warm_target == {oscillator_warmup_count, 6'h00})
		else $error("oscillator warm length wrong");
	chk_warm_order: assert property (@(posedge clk) disable iff (rst)
		(state == srw_pkg::SRW_SEND && $past(state) != srw_pkg::SRW_SEND)
		|-> $past(state) == srw_pkg::SRW_WARM_AMP && pa_on && div_on)
		else $error("send entered without warm-up");
	chk_empty_set: assert property (@(posedge clk) disable iff (rst)
		(transfer && !wr_group) |=> data_empty) else $error("empty flag not set on transfer");
	chk_empty_pending: assert property (@(posedge clk) disable iff (rst)
		pending |-> !data_empty) else $error("empty flag set while byte still held");
	chk_rate_bound: assert property (@(posedge clk) disable iff (rst)
		rate_cnt < rate_lim) else $error("rate counter past divisor");
endmodule

/* srw_host.sv */
// Purpose: Software-side model that reaches the serializer registers
// Assumes: One access at a time, strobes launched on the falling edge
// Notes: Qualifiers are scrambled between accesses so stale values never help
`timescale 1ns/1ns

// ************************************************************
// Register access model
// ************************************************************
module srw_host (
	input wire logic clk,
	output srw_pkg::srw_sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata
);
	initial begin
		sfr_req = '0;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_req.wr = 1'b1;
		sfr_req.addr = a;
		sfr_req.wdata = d;
		@(negedge clk);
		sfr_req.wr = 1'b0;
		sfr_req.addr = ~a;
		sfr_req.wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sfr_req.rd = 1'b1;
		sfr_req.addr = a;
		@(negedge clk);
		sfr_req.rd = 1'b0;
		sfr_req.addr = ~a;
		d = sfr_rdata;
	endtask
endmodule

/* serializer_rate_warmup_tb.sv */
// Purpose: Self-checking bench for the serializer rate and warm-up block
// Assumes: Inputs change on the falling edge; clk stands for the system clock
// Notes: Warm-up latency is judged in a window, since tick phase is not fixed
`timescale 1ns/1ns

module serializer_rate_warmup_tb;
	logic clk, rst, ce, ods_enable, fsk_mode;
	logic [2:0] ckdiv, gw;
	logic [1:0] sc;
	srw_pkg::srw_sfr_req_t sfr_req;
	logic [7:0] sfr_rdata;
	logic data_empty, sym_out, sym_strobe, pa_on, div_on, lc_on;
	int err_count, n_compared, cycles;

	srw_serializer uut (.clk(clk), .rst(rst), .ce(ce), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .ods_enable(ods_enable), .fsk_mode(fsk_mode),
		.serializer_clock_divider(ckdiv), .group_width(gw), .shift_ctrl(sc),
		.data_empty(data_empty), .sym_out(sym_out), .sym_strobe(sym_strobe),
		.pa_on(pa_on), .div_on(div_on), .lc_oscillator_on(lc_on));
	srw_host host (.clk(clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));

	// ************************************************************
	// Clock, timeout and reporting
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Whole run needs about a thousand cycles; the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_count = err_count + 1;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("compared=%0d mismatches=%0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_range(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	// ************************************************************
	// Helpers
	// ************************************************************
	// Selector 0 waits for empty, 1 for amplifier off, 2 for a symbol strobe
	task automatic wait_lvl(input int sel, output int n);
		logic s;
		n = 0;
		s = 1'b0;
		while (s !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
			s = (sel == 0) ? data_empty : (sel == 1) ? ~pa_on : sym_strobe;
		end
		// A wait that runs out is a failure in its own right
		if (s !== 1'b1) begin
			err_count++;
			$display("[ERR] t=%0t wait %0d got=%h exp=%h", $time, sel, s, 1'b1);
		end
	endtask

	task automatic set_ctl(input logic en, input logic f, input logic [2:0] d,
		input logic [2:0] w, input logic [1:0] m);
		@(negedge clk);
		ods_enable = en;
		fsk_mode = f;
		ckdiv = d;
		gw = w;
		sc = m;
	endtask

	task automatic cfg(input logic [14:0] r, input logic [3:0] lc, input logic [3:0] dv,
		input logic [3:0] pa);
		host.wr(srw_pkg::ADDR_SYMBOL_RATE_LOW, r[7:0]);
		host.wr(srw_pkg::ADDR_SYMBOL_RATE_HIGH, {1'b0, r[14:8]});
		host.wr(srw_pkg::ADDR_WARMUP_DIV_AMP, {dv, pa});
		host.wr(srw_pkg::ADDR_WARMUP_OSC, {4'h0, lc});
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs();
		logic [7:0] d;
		cmp_bit(data_empty, 1'b1);
		for (int i = 0; i < 5; i++) begin
			host.rd(srw_pkg::ADDR_SYMBOL_GROUP_IN + 8'(i), d);
			cmp_byte(d, srw_pkg::REG_RESET);
		end
		host.rd(8'hB0, d);
		cmp_byte(d, srw_pkg::READ_UNMAPPED);
		for (int i = 1; i < 5; i++) begin
			host.wr(srw_pkg::ADDR_SYMBOL_GROUP_IN + 8'(i), 8'hFF);
			host.rd(srw_pkg::ADDR_SYMBOL_GROUP_IN + 8'(i), d);
			cmp_byte(d, (i == 2) ? 8'h7F : (i == 4) ? 8'h0F : 8'hFF);
		end
		ce = 1'b0;
		host.wr(srw_pkg::ADDR_SYMBOL_RATE_LOW, 8'h12);
		ce = 1'b1;
		host.rd(srw_pkg::ADDR_SYMBOL_RATE_LOW, d);
		cmp_byte(d, 8'hFF);
		$display("t_regs done");
	endtask

	task automatic t_empty();
		logic [7:0] d;
		int n;
		set_ctl(1'b0, 1'b1, 3'h1, 3'h7, 2'h0);
		host.wr(srw_pkg::ADDR_SYMBOL_GROUP_IN, 8'h3C);
		cmp_bit(data_empty, 1'b0);
		wait_lvl(0, n);
		cmp_range(n, 1, 4);
		host.rd(srw_pkg::ADDR_SYMBOL_GROUP_IN, d);
		cmp_byte(d, 8'h3C);
		host.wr(srw_pkg::ADDR_SYMBOL_GROUP_IN, 8'hA5);
		wait_lvl(0, n);
		cmp_range(n, 1, 4);
		$display("t_empty done");
	endtask

	// Two groups queued; warm-up LC 64, divider 8, amplifier 3 ticks of 2 clocks
	task automatic t_tx();
		logic [15:0] e;
		int n;
		e = 16'hA53C;
		cfg(15'h0003, 4'h1, 4'h2, 4'h3);
		set_ctl(1'b1, 1'b1, 3'h1, 3'h7, 2'h0);
		repeat (2) @(negedge clk);
		cmp_bit(lc_on, 1'b1);
		wait_lvl(2, n);
		cmp_range(n + 2, 142, 164);
		cmp_bit(div_on & pa_on, 1'b1);
		cmp_bit(sym_out, e[0]);
		for (int i = 1; i < 16; i++) begin
			wait_lvl(2, n);
			cmp_range(n, 6, 6);
			cmp_bit(sym_out, e[i]);
		end
		wait_lvl(1, n);
		cmp_range(n, 1, 12);
		cmp_bit(lc_on | div_on | sym_out, 1'b0);
		set_ctl(1'b0, 1'b1, 3'h1, 3'h7, 2'h0);
		$display("t_tx done");
	endtask

	task automatic t_runout();
		logic [3:0] e;
		int n;
		cfg(15'h0002, 4'h1, 4'h1, 4'h1);
		for (int m = 1; m < 4; m++) begin
			e = (m == 1) ? 4'h5 : (m == 2) ? 4'h1 : 4'hD;
			host.wr(srw_pkg::ADDR_SYMBOL_GROUP_IN, 8'h01);
			set_ctl(1'b1, 1'b1, 3'h0, 3'h1, 2'(m));
			for (int i = 0; i < 4; i++) begin
				wait_lvl(2, n);
				cmp_bit(sym_out, e[i]);
			end
			set_ctl(1'b0, 1'b1, 3'h0, 3'h1, 2'(m));
			repeat (3) @(negedge clk);
		end
		$display("t_runout done");
	endtask

	// OOK 0 then 1: the one symbol waits for a full second warm-up
	task automatic t_ook();
		int n;
		cfg(15'h0002, 4'h2, 4'h1, 4'h1);
		host.wr(srw_pkg::ADDR_SYMBOL_GROUP_IN, 8'h02);
		set_ctl(1'b1, 1'b0, 3'h0, 3'h2, 2'h2);
		wait_lvl(2, n);
		cmp_bit(sym_out, 1'b0);
		wait_lvl(2, n);
		cmp_range(n, 133, 145);
		cmp_bit(sym_out & pa_on, 1'b1);
		set_ctl(1'b0, 1'b1, 3'h0, 3'h2, 2'h0);
		repeat (3) @(negedge clk);
		$display("t_ook done");
	endtask

	// Sixteen held bytes fill the buffer; a seventeenth waits, then all drain
	task automatic t_fifo();
		int n, cnt;
		cfg(15'h0002, 4'h0, 4'h0, 4'h0);
		for (int i = 0; i < 16; i++) begin
			host.wr(srw_pkg::ADDR_SYMBOL_GROUP_IN, 8'(i));
			wait_lvl(0, n);
		end
		host.wr(srw_pkg::ADDR_SYMBOL_GROUP_IN, 8'h40);
		repeat (6) @(negedge clk);
		cmp_bit(data_empty, 1'b0);
		set_ctl(1'b1, 1'b1, 3'h0, 3'h1, 2'h0);
		cnt = 0;
		for (int k = 0; k < 2000; k++) begin
			@(negedge clk);
			cnt += (sym_strobe === 1'b1) ? 1 : 0;
			if (k > 4 && lc_on !== 1'b1) begin
				break;
			end
		end
		cmp_range(cnt, 34, 34);
		cmp_bit(data_empty, 1'b1);
		$display("t_fifo done");
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		err_count = 0;
		n_compared = 0;
		cycles = 0;
		rst = 1'b1;
		ce = 1'b1;
		ods_enable = 1'b0;
		fsk_mode = 1'b1;
		ckdiv = 3'h0;
		gw = 3'h7;
		sc = 2'h0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_regs();
		t_empty();
		t_tx();
		t_runout();
		t_ook();
		t_fifo();
		stop_test();
	end
endmodule
